// ---- design/ifp_consts.svh ----
// Named constants for the instruction fetch pipeline
`ifndef IFP_CONSTS_SVH
`define IFP_CONSTS_SVH

`define IFP_PC_W          21
`define IFP_PC_RESET      21'h000000
`define IFP_PC_STEP       21'h000002
`define IFP_TPTR_RESET    21'h000000
`define IFP_TPTR_STEP     21'h000001
`define IFP_TPTR_PAD      5'h00
`define IFP_DADDR_ZERO    12'h000
`define IFP_BYTE_ZERO     8'h00
`define IFP_WORD_ZERO     16'h0000

`define IFP_SECOND_TAG    4'hF
`define IFP_PCL_ADDR      12'hFF9
`define IFP_BANK_ACCESS   4'hF
`define IFP_BANK_LOW      4'h0

`define IFP_OP_ABSOLUTE_JUMP       8'hEF
`define IFP_OP_CALL       7'h76
`define IFP_OP_LFSR       8'hEE
`define IFP_OP_MEMORY_TO_MEMORY_MOVE      4'hC
`define IFP_OP_BRA        5'h1A
`define IFP_OP_ADD_WORKING_TO_FILE      6'h09
`define IFP_OP_MOVLW      8'h0E
`define IFP_OP_TSTFSZ     7'h33
`define IFP_OP_TBLRD      15'h0004

`endif

// ---- design/ifp_pkg.sv ----
// Types shared by the instruction fetch pipeline modules
package ifp_pkg;

    typedef enum logic [1:0] {
        phase_one,
        phase_two,
        phase_three,
        phase_four
    } ifp_phase_e;

    typedef logic [15:0] ifp_word_t;
    typedef logic [20:0] ifp_addr_t;

endpackage : ifp_pkg

// ---- design/ifp_pmem_if.sv ----
// Link between the core and its program memory
`timescale 1ns/1ps
interface ifp_pmem_if #(parameter int AW = 12);
    logic [AW-1:0] fetch_addr;
    logic [15:0]   fetch_data;
    logic [20:0]   tbl_addr;
    logic [7:0]    tbl_data;
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [15:0]   wr_data;

    modport core (
        output fetch_addr,
        output tbl_addr,
        output wr_en,
        output wr_addr,
        output wr_data,
        input  fetch_data,
        input  tbl_data
    );

    modport mem (
        input  fetch_addr,
        input  tbl_addr,
        input  wr_en,
        input  wr_addr,
        input  wr_data,
        output fetch_data,
        output tbl_data
    );
endinterface : ifp_pmem_if

// ---- design/ifp_prog_mem.sv ----
// Program memory: word fetch port, byte table port, load port
`timescale 1ns/1ps
module ifp_prog_mem #(
    parameter int AW = 12
) (
    input wire logic clk_in,
    ifp_pmem_if.mem  pm
);
    logic [15:0] mem_q [2**AW];
    logic [15:0] tbl_word;

    // Table port sees words; low address bit picks the byte
    assign tbl_word = mem_q[pm.tbl_addr[AW:1]];

    always_ff @(posedge clk_in) begin
        if (pm.wr_en) begin
            mem_q[pm.wr_addr] <= pm.wr_data;
        end
    end

    always_ff @(posedge clk_in) begin
        pm.fetch_data <= mem_q[pm.fetch_addr];
    end

    always_ff @(posedge clk_in) begin
        pm.tbl_data <= pm.tbl_addr[0] ? tbl_word[15:8] : tbl_word[7:0];
    end
endmodule : ifp_prog_mem

// ---- design/ifp_core.sv ----
// Instruction fetch and execute sequencing core
`timescale 1ns/1ps
`include "ifp_consts.svh"
module ifp_core import ifp_pkg::*; #(
    parameter int PMEM_AW = 12
) (
    input  wire logic               SYS_CLK_IN,
    input  wire logic               RSTN_IN,
    input  wire logic               PMEM_WR_EN_IN,
    input  wire logic [PMEM_AW-1:0] PMEM_WR_ADDR_IN,
    input  wire logic [15:0]        PMEM_WR_DATA_IN,
    input  wire logic [7:0]         DMEM_RDATA_IN,
    output logic      [11:0]        DMEM_ADDR_OUT,
    output logic                    DMEM_RD_OUT,
    output logic                    DMEM_WR_OUT,
    output logic      [7:0]         DMEM_WDATA_OUT,
    output logic      [20:0]        PC_OUT,
    output logic      [1:0]         PHASE_OUT,
    output logic      [15:0]        IHR_OUT,
    output logic                    EXEC_VALID_OUT,
    output logic      [7:0]         WORKING_OUT,
    output logic      [20:0]        TABLE_POINTER_OUT,
    output logic      [7:0]         TABLE_LATCH_OUT
);
    ifp_pmem_if #(.AW(PMEM_AW)) pm ();

    ifp_phase_e phase_q;
    ifp_phase_e phase_d;
    ifp_addr_t  pc_q;
    ifp_addr_t  pc_d;
    ifp_addr_t  fetch_addr_q;
    ifp_word_t  fetch_q;
    ifp_word_t  instruction_holding_register_q;
    ifp_word_t  first_q;
    logic       fetch_valid_q;
    logic       ihr_valid_q;
    logic       pending_q;
    logic       pend_mm_q;
    logic [7:0] working_register_q;
    logic [7:0] table_latch_q;
    logic [7:0] operand_q;
    ifp_addr_t  table_pointer_q;
    logic [11:0] dmem_addr_q;
    logic       dmem_rd_q;
    logic       dmem_wr_q;
    logic [7:0] dmem_wdata_q;

    // Decoders shared by the execute stage and the read look-ahead
    function automatic logic f_is_add_working_to_file(input ifp_word_t w);
        f_is_add_working_to_file = (w[15:10] == `IFP_OP_ADD_WORKING_TO_FILE);
    endfunction : f_is_add_working_to_file

    function automatic logic f_is_tstfsz(input ifp_word_t w);
        f_is_tstfsz = (w[15:9] == `IFP_OP_TSTFSZ);
    endfunction : f_is_tstfsz

    function automatic logic f_is_second(input ifp_word_t w);
        f_is_second = (w[15:12] == `IFP_SECOND_TAG);
    endfunction : f_is_second

    // Access bank: bit 8 clear and high half maps to the top bank
    function automatic logic [11:0] f_access_addr(input ifp_word_t w);
        f_access_addr = (w[7] && !w[8]) ? {`IFP_BANK_ACCESS, w[7:0]}
                                         : {`IFP_BANK_LOW, w[7:0]};
    endfunction : f_access_addr

    wire phase_is_one   = (phase_q == phase_one);
    wire phase_is_two   = (phase_q == phase_two);
    wire phase_is_three = (phase_q == phase_three);
    wire phase_is_four  = (phase_q == phase_four);

    // Execute-stage decode of the holding register
    wire       ex        = ihr_valid_q;
    wire [15:0] ihr      = instruction_holding_register_q;
    wire       op_absolute_jump   = ex && (ihr[15:8] == `IFP_OP_ABSOLUTE_JUMP || ihr[15:9] == `IFP_OP_CALL);
    wire       op_lfsr1  = ex && (ihr[15:8] == `IFP_OP_LFSR);
    wire       op_movff1 = ex && (ihr[15:12] == `IFP_OP_MEMORY_TO_MEMORY_MOVE);
    wire       op_bra    = ex && (ihr[15:11] == `IFP_OP_BRA);
    wire       op_add_working_to_file  = ex && f_is_add_working_to_file(ihr);
    wire       op_tst    = ex && f_is_tstfsz(ihr);
    wire       op_movlw  = ex && (ihr[15:8] == `IFP_OP_MOVLW);
    wire       op_tblrd  = ex && (ihr[15:1] == `IFP_OP_TBLRD);
    wire       word2     = ex && f_is_second(ihr) && pending_q;
    wire       mm_exec   = word2 && pend_mm_q;
    wire       lfsr_exec = word2 && !pend_mm_q;
    wire [11:0] ihr_addr = f_access_addr(ihr);
    // computed jump via PC low byte
    wire       to_pcl    = op_add_working_to_file && ihr[9] && (ihr_addr == `IFP_PCL_ADDR);
    wire [7:0] file_sum  = operand_q + working_register_q;
    wire [7:0] pcl_sum   = fetch_addr_q[7:0] + working_register_q;
    wire       skip      = op_tst && (operand_q == `IFP_BYTE_ZERO);
    // relative branches, computed jumps and taken skips discard the word already fetched
    wire       flush     = op_bra || to_pcl || skip;

    // word address into PC bits 20 to 1
    wire [20:0] absolute_jump_target = {pm.fetch_data[11:0], ihr[7:0], 1'b0};
    // word offset doubled to bytes
    // Base is the word after the branch, the one fetched meanwhile;
    // pc_q already runs one word further ahead at this point
    wire [20:0] rel_base    = fetch_addr_q;
    wire [20:0] bra_target  = rel_base + {{9{ihr[10]}}, ihr[10:0], 1'b0};
    wire [20:0] pcl_target  = {rel_base[20:8], pcl_sum[7:1], 1'b0};
    wire [20:0] pc_seq      = pc_q + `IFP_PC_STEP;
    wire [20:0] tptr_step   = table_pointer_q + `IFP_TPTR_STEP;
    wire [20:0] lfsr_value  = {`IFP_TPTR_PAD, first_q[3:0], ihr[11:0]};

    // Look-ahead on the word entering execution, so phase two reads in time
    wire        nxt_mm   = f_is_second(fetch_q) && pending_q && pend_mm_q;
    wire        rd_next  = fetch_valid_q
                           && (f_is_add_working_to_file(fetch_q) || f_is_tstfsz(fetch_q) || nxt_mm);
    wire [11:0] rd_addr  = nxt_mm ? first_q[11:0] : f_access_addr(fetch_q);
    wire        wr_need  = (op_add_working_to_file && ihr[9] && !to_pcl) || mm_exec;
    wire [11:0] wr_addr  = mm_exec ? ihr[11:0] : ihr_addr;
    wire [7:0]  wr_data  = mm_exec ? DMEM_RDATA_IN : DMEM_RDATA_IN + working_register_q;

    always_comb begin
        case (phase_q)
            phase_one:   phase_d = phase_two;
            phase_two:   phase_d = phase_three;
            phase_three: phase_d = phase_four;
            phase_four:  phase_d = phase_one;
            default:     phase_d = phase_one;
        endcase
    end

    // Loads land only in phase four, so they never meet the step
    // PC stays even, bit zero forced low
    always_comb begin
        pc_d = pc_q;
        if (phase_is_one) begin
            pc_d = pc_seq;
        end else if (phase_is_four && op_absolute_jump) begin
            pc_d = absolute_jump_target;
        end else if (phase_is_four && op_bra) begin
            pc_d = bra_target;
        end else if (phase_is_four && to_pcl) begin
            pc_d = pcl_target;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            phase_q <= phase_one;
        end else begin
            phase_q <= phase_d;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            pc_q         <= `IFP_PC_RESET;
            fetch_addr_q <= `IFP_PC_RESET;
        end else begin
            pc_q <= pc_d;
            if (phase_is_one) begin
                fetch_addr_q <= pc_q;
            end
        end
    end

    // A flushed word still loads but is marked empty
    // fetched word captured in phase four
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            fetch_q       <= `IFP_WORD_ZERO;
            fetch_valid_q <= 1'b0;
        end else if (phase_is_four) begin
            fetch_q       <= pm.fetch_data;
            fetch_valid_q <= !flush;
        end
    end

    // word moves into holding register in phase one
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            instruction_holding_register_q <= `IFP_WORD_ZERO;
            ihr_valid_q                    <= 1'b0;
        end else if (phase_is_one) begin
            instruction_holding_register_q <= fetch_q;
            ihr_valid_q                    <= fetch_valid_q;
        end
    end

    // first word held while its second word follows
    // second word supplies 12 literal bits
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            pending_q <= 1'b0;
            pend_mm_q <= 1'b0;
            first_q   <= `IFP_WORD_ZERO;
        end else if (phase_is_four) begin
            pending_q <= op_lfsr1 || op_movff1;
            pend_mm_q <= op_movff1;
            first_q   <= ihr;
        end
    end

    // Operand is sampled one cycle after the read strobe
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            operand_q <= `IFP_BYTE_ZERO;
        end else if (phase_is_three) begin
            operand_q <= DMEM_RDATA_IN;
        end
    end

    // read strobe in phase two, write strobe in phase four
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            dmem_rd_q <= 1'b0;
            dmem_wr_q <= 1'b0;
        end else begin
            dmem_rd_q <= phase_is_one && rd_next;
            dmem_wr_q <= phase_is_three && wr_need;
        end
    end

    // Write address replaces read address once the operand is taken
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            dmem_addr_q  <= `IFP_DADDR_ZERO;
            dmem_wdata_q <= `IFP_BYTE_ZERO;
        end else if (phase_is_one) begin
            dmem_addr_q <= rd_addr;
        end else if (phase_is_three) begin
            dmem_addr_q  <= wr_addr;
            dmem_wdata_q <= wr_data;
        end
    end

    // Working register updates land with the destination phase
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            working_register_q <= `IFP_BYTE_ZERO;
        end else if (phase_is_four && op_movlw) begin
            working_register_q <= ihr[7:0];
        end else if (phase_is_four && op_add_working_to_file && !ihr[9]) begin
            working_register_q <= file_sum;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            table_pointer_q <= `IFP_TPTR_RESET;
            table_latch_q   <= `IFP_BYTE_ZERO;
        end else if (phase_is_four) begin
            if (op_tblrd) begin
                table_latch_q <= pm.tbl_data;
            end
            if (lfsr_exec) begin
                table_pointer_q <= lfsr_value;
            end else if (op_tblrd && ihr[0]) begin
                // Only the post-increment form moves the pointer
                table_pointer_q <= tptr_step;
            end
        end
    end

    // Fetch and load ports see word addresses; table port gets the byte address
    assign pm.fetch_addr = fetch_addr_q[PMEM_AW:1];
    assign pm.tbl_addr   = table_pointer_q;
    assign pm.wr_en      = PMEM_WR_EN_IN;
    assign pm.wr_addr    = PMEM_WR_ADDR_IN;
    assign pm.wr_data    = PMEM_WR_DATA_IN;

    ifp_prog_mem #(
        .AW (PMEM_AW)
    ) u_prog_mem (
        .clk_in (SYS_CLK_IN),
        .pm     (pm.mem)
    );

    // Every output comes straight from a register
    assign DMEM_ADDR_OUT     = dmem_addr_q;
    assign DMEM_RD_OUT       = dmem_rd_q;
    assign DMEM_WR_OUT       = dmem_wr_q;
    assign DMEM_WDATA_OUT    = dmem_wdata_q;
    assign PC_OUT            = pc_q;
    assign PHASE_OUT         = phase_q;
    assign IHR_OUT           = instruction_holding_register_q;
    assign EXEC_VALID_OUT    = ihr_valid_q;
    assign WORKING_OUT       = working_register_q;
    assign TABLE_POINTER_OUT = table_pointer_q;
    assign TABLE_LATCH_OUT   = table_latch_q;
endmodule : ifp_core

// ---- tb/ifp_core_chk.sv ----
// Port checker for the fetch pipeline core
`timescale 1ns/1ps
module ifp_core_chk (
    input wire logic        SYS_CLK_IN,
    input wire logic        RSTN_IN,
    input wire logic        DMEM_RD_OUT,
    input wire logic        DMEM_WR_OUT,
    input wire logic [20:0] PC_OUT,
    input wire logic [1:0]  PHASE_OUT,
    input wire logic [15:0] IHR_OUT,
    input wire logic        EXEC_VALID_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // First cycle only fetches
    sequence s_fetch_only;
        !EXEC_VALID_OUT [*5];
    endsequence
    sequence s_exec_on;
        EXEC_VALID_OUT;
    endsequence
    phase_order_a: assert property (
        RSTN_IN |=> PHASE_OUT == $past(PHASE_OUT) + 2'h1) else $error("phase order broken");
    pc_step_a: assert property (
        RSTN_IN && PHASE_OUT == 2'h0 |=> PC_OUT == $past(PC_OUT) + 21'h2)
        else $error("pc step wrong");
    pc_hold_a: assert property (
        PHASE_OUT inside {2'h1, 2'h2} |=> $stable(PC_OUT)) else $error("pc moved mid cycle");
    pc_even_a: assert property (
        PC_OUT[0] == 1'b0) else $error("pc odd");
    ihr_load_a: assert property (
        $changed(IHR_OUT) |-> $past(PHASE_OUT) == 2'h0) else $error("ihr load phase");
    rd_phase_a: assert property (
        DMEM_RD_OUT |-> PHASE_OUT == 2'h1 ##1 !DMEM_RD_OUT) else $error("read phase");
    wr_phase_a: assert property (
        DMEM_WR_OUT |-> PHASE_OUT == 2'h3 ##1 !DMEM_WR_OUT) else $error("write phase");
    exec_start_a: assert property (
        $rose(RSTN_IN) |-> s_fetch_only ##1 s_exec_on) else $error("exec start");
    bubble_edge_a: assert property (
        $changed(EXEC_VALID_OUT) |-> $past(PHASE_OUT) == 2'h0) else $error("bubble edge");
    wr_seen_c: cover property (DMEM_WR_OUT && EXEC_VALID_OUT);
endmodule : ifp_core_chk

// ---- tb/ifp_dmem_model.sv ----
// Data memory model facing the core data port
`timescale 1ns/1ps
module ifp_dmem_model (
    input  wire logic        clk_in,
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic [11:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    output logic      [7:0]  rdata_out
);
    logic [7:0] mem [0:4095];
    initial rdata_out = 8'h00;
    always @(posedge clk_in) begin
        // Stale data flips so a late sample shows
        rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
        if (wr_in) begin
            mem[addr_in] <= wdata_in;
        end
    end
endmodule : ifp_dmem_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the fetch pipeline core
`timescale 1ns/1ps
module tb_top import ifp_pkg::*;;
    localparam int AW = 6;
    logic          sys_clk;
    logic          rstn;
    logic          pm_wr_en;
    logic [AW-1:0] pm_wr_addr;
    logic [15:0]   pm_wr_data;
    logic [7:0]    dm_rdata;
    logic [11:0]   dm_addr;
    logic          dm_rd;
    logic          dm_wr;
    logic [7:0]    dm_wdata;
    logic [20:0]   pc;
    logic [1:0]    phase;
    logic [15:0]   ihr;
    logic          exec_valid;
    logic [7:0]    working;
    logic [20:0]   tptr;
    logic [7:0]    tlatch;
    logic [7:0]    k1;
    logic [15:0]   prog [0:31];
    logic [19:0]   exp_q [$];
    integer        seed;
    integer        mismatches;
    integer        n_compared;
    integer        n_wr;
    integer        cycles;

    ifp_core #(.PMEM_AW(AW)) u_ifp_core (.SYS_CLK_IN(sys_clk), .RSTN_IN(rstn),
        .PMEM_WR_EN_IN(pm_wr_en), .PMEM_WR_ADDR_IN(pm_wr_addr), .PMEM_WR_DATA_IN(pm_wr_data),
        .DMEM_RDATA_IN(dm_rdata), .DMEM_ADDR_OUT(dm_addr), .DMEM_RD_OUT(dm_rd),
        .DMEM_WR_OUT(dm_wr), .DMEM_WDATA_OUT(dm_wdata), .PC_OUT(pc), .PHASE_OUT(phase),
        .IHR_OUT(ihr), .EXEC_VALID_OUT(exec_valid), .WORKING_OUT(working),
        .TABLE_POINTER_OUT(tptr), .TABLE_LATCH_OUT(tlatch));
    ifp_dmem_model u_ifp_dmem_model (.clk_in(sys_clk), .rd_in(dm_rd), .wr_in(dm_wr),
        .addr_in(dm_addr), .wdata_in(dm_wdata), .rdata_out(dm_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // Unlisted write means a flushed or skipped word ran
    always @(posedge sys_clk) begin
        if (rstn && dm_wr && dm_addr !== 12'hFF9) begin
            n_wr = n_wr + 1;
            check("dmem write", {dm_addr, dm_wdata}, exp_q.size() ? exp_q.pop_front() : '1);
        end
    end

    // Ceiling well above the program run
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 1500) begin
            mismatches = mismatches + 1;
            tally_and_finish();
        end
    end

    initial begin
        seed = 6185;
        mismatches = 0;
        n_compared = 0;
        n_wr = 0;
        cycles = 0;
        rstn = 1'b0;
        pm_wr_en = 1'b0;
        pm_wr_addr = '0;
        pm_wr_data = 16'h0000;
        k1 = $random(seed);
        for (int a = 0; a < 4096; a++) begin
            u_ifp_dmem_model.mem[a] = $random(seed);
        end
        u_ifp_dmem_model.mem[12'h030] = 8'h00;
        prog = '{{8'h0E, k1}, 16'hC010, 16'hF020, 16'h2621, 16'h6630, 16'hC011, 16'hF040,
            16'hEE00, 16'hF003, 16'h0009, 16'h0008, 16'hEF14, 16'hF000, 16'h2624,
            16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hD002,
            16'h2625, 16'h2626, 16'h0E04, 16'h26F9, 16'h2625, 16'h2627, 16'hC012,
            16'hF022, 16'h2623, 16'hD7FF, 16'hFFFF};
        exp_q.push_back({12'h020, u_ifp_dmem_model.mem[12'h010]});
        exp_q.push_back({12'h021, k1 + u_ifp_dmem_model.mem[12'h021]});
        exp_q.push_back({12'h022, u_ifp_dmem_model.mem[12'h012]});
        exp_q.push_back({12'h023, u_ifp_dmem_model.mem[12'h023] + 8'h04});
        fork
            begin
                repeat (9) @(posedge sys_clk);
                check("reset pc", pc, 21'h0);
                check("reset valid", exec_valid, 1'b0);
                @(posedge sys_clk);
                rstn <= 1'b1;
            end
            begin
                // Upper words load while the core already runs
                for (int i = 0; i < 32; i++) begin
                    @(posedge sys_clk);
                    pm_wr_en <= 1'b1;
                    pm_wr_addr <= AW'(i);
                    pm_wr_data <= prog[i];
                end
                @(posedge sys_clk);
                pm_wr_en <= 1'b0;
            end
        join
        for (int t = 0; t < 600 && n_wr < 4; t++) begin
            @(posedge sys_clk);
        end
        repeat (80) @(posedge sys_clk);
        check("pending writes", exp_q.size(), 32'h0);
        check("table pointer", tptr, 21'h000004);
        check("table latch", tlatch, 8'h20);
        check("working", working, 8'h04);
        tally_and_finish();
    end
endmodule : tb_top

bind ifp_core ifp_core_chk u_ifp_core_chk (.SYS_CLK_IN(SYS_CLK_IN), .RSTN_IN(RSTN_IN),
    .DMEM_RD_OUT(DMEM_RD_OUT), .DMEM_WR_OUT(DMEM_WR_OUT), .PC_OUT(PC_OUT),
    .PHASE_OUT(PHASE_OUT), .IHR_OUT(IHR_OUT), .EXEC_VALID_OUT(EXEC_VALID_OUT));
